// ===== async_serial_transceiver_fifo.sv
// full-duplex asynchronous serial transceiver with four-word fifos each way
// What this block does
// - alt_pin_select high uses alternate tx/rx pins, low uses primary pins.
// - format_select picks 8E, 8O, 8N or 9N data framing.
// - stop_select picks one or two stop bits per transmitted frame.
// - format resets to eight data bits, no parity, one stop bit.
// - enabled and idle transmitter loads a written word and starts shifting.
// - word written before tx_enable starts at once when tx_enable rises.
// - tx fifo holds four 9-bit words; tx_full reports a full fifo.
// - writes into a full tx fifo are dropped, contents and pointers kept.
// - any reset empties both fifos.
// - tx irq pulses per fifo-to-shift transfer, or only when it empties fifo.
// - send_break forces the tx line low over everything except module disable.
// - rx fifo holds four words; rx_data_avail shows it is non-empty.
// - reading an empty rx fifo returns stale data without advancing.
// - each read of a non-empty fifo advances the head; error bits follow the head word.
// - rx irq pulses per transfer, or at three or four words held.
// - full fifo at stop completion sets overrun and halts reception.
// - a low stop bit, either of two, sets the stored framing error.
// - wrong parity in parity modes sets the stored parity error.
// - rx_idle low from start bit detection to stop completion.
// - long break ends frame, loads zeros with framing error, sets idle.
// - after a break frame the line must return high before new start.
// - module disable empties fifos, clears baud counter, flags and break.
// - tx line idles high while enabled and not transmitting.
`timescale 1ns/10ps
module async_serial_transceiver_fifo (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // configuration
    input wire logic module_enable,
    input wire logic alt_pin_select,
    input wire logic [1:0] format_select,
    input wire logic stop_select,
    input wire logic tx_enable,
    input wire logic send_break,
    input wire logic tx_irq_select,
    input wire logic [1:0] rx_irq_select,
    input wire logic [15:0] baud_div,
    // transmit data
    input wire logic tx_wr_stb,
    input wire logic [8:0] tx_wr_data,
    // receive data
    input wire logic rx_rd_stb,
    output logic [8:0] rx_rd_data,
    // status and events
    input wire logic overrun_clr,
    output logic tx_full,
    output logic tx_shift_empty,
    output logic rx_data_avail,
    output logic overrun_err,
    output logic framing_err,
    output logic parity_err,
    output logic rx_idle,
    output logic tx_irq_flag,
    output logic rx_irq_flag,
    // serial pins
    input wire logic primary_rx_pin,
    input wire logic alt_rx_pin,
    output logic primary_tx_pin,
    output logic alt_tx_pin
);
    fifo_if #(.W(uart_pkg::DATA_W)) txf();
    fifo_if #(.W(uart_pkg::RX_ENTRY_W)) rxf();

    word_fifo #(.W(uart_pkg::DATA_W)) u_tx_fifo (
        .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .f(txf.store));
    word_fifo #(.W(uart_pkg::RX_ENTRY_W)) u_rx_fifo (
        .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .f(rxf.store));

    // ================================
    // configuration and baud tick
    logic [1:0] fmt_q;
    logic stop_q;
    logic alt_sel_q;
    logic [15:0] div_q;
    logic tick;
    logic has_par;
    logic [3:0] nbits;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            fmt_q <= uart_pkg::FORMAT_RESET;
            stop_q <= uart_pkg::STOP_RESET;
            alt_sel_q <= 1'b0;
        end else if (ce) begin
            fmt_q <= format_select;
            stop_q <= stop_select;
            alt_sel_q <= alt_pin_select;
        end
    end

    assign has_par = (fmt_q == uart_pkg::FMT_8E) || (fmt_q == uart_pkg::FMT_8O);
    assign nbits = (fmt_q == uart_pkg::FMT_9N) ? uart_pkg::BITS_9 : uart_pkg::BITS_8;
    assign tick = ce && module_enable && (div_q == baud_div);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) div_q <= uart_pkg::DIV_RESET;
        else if (ce) begin
            if (!module_enable || tick) div_q <= uart_pkg::DIV_RESET;
            else div_q <= div_q + 16'h0001;
        end
    end

    // ================================
    // transmitter
    uart_pkg::tx_state_t tx_st_q;
    logic [3:0] tx_phase_q;
    logic [3:0] tx_bit_q;
    logic [8:0] tx_sr_q;
    logic tx_par_q;
    logic tx_stop2_q;
    logic tx_line_q;
    logic tx_irq_q;
    logic tx_pop;
    logic tx_bit;

    assign txf.wr_valid = tx_wr_stb && module_enable;
    assign txf.wr_data = tx_wr_data;
    assign txf.flush = !module_enable;
    // break blocks loading so a frame is not cut by a held break
    assign tx_pop = ce && module_enable && tx_enable && !send_break
        && tx_st_q == uart_pkg::TX_IDLE && txf.rd_valid;
    assign txf.rd_ready = tx_pop;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_st_q <= uart_pkg::TX_IDLE;
            tx_phase_q <= 4'h0;
            tx_bit_q <= 4'h0;
            tx_sr_q <= 9'h000;
            tx_par_q <= 1'b0;
            tx_stop2_q <= 1'b0;
        end else if (ce) begin
            if (!module_enable) begin
                tx_st_q <= uart_pkg::TX_IDLE;
            end else if (tx_pop) begin
                // phase restarts from zero, so the start bit begins at once
                tx_sr_q <= txf.rd_data;
                tx_par_q <= (fmt_q == uart_pkg::FMT_8E) ? ^txf.rd_data[7:0]
                                                        : ~^txf.rd_data[7:0];
                tx_phase_q <= 4'h0;
                tx_st_q <= uart_pkg::TX_START;
            end else if (tick && tx_st_q != uart_pkg::TX_IDLE) begin
                tx_phase_q <= tx_phase_q + 4'h1;
                if (tx_phase_q == uart_pkg::PHASE_LAST) begin
                    case (tx_st_q)
                        uart_pkg::TX_START: begin
                            tx_st_q <= uart_pkg::TX_DATA;
                            tx_bit_q <= 4'h0;
                        end
                        uart_pkg::TX_DATA: begin
                            tx_sr_q <= {1'b0, tx_sr_q[8:1]};
                            tx_bit_q <= tx_bit_q + 4'h1;
                            tx_stop2_q <= 1'b0;
                            if (tx_bit_q == nbits - 4'h1) begin
                                tx_st_q <= has_par ? uart_pkg::TX_PAR
                                                   : uart_pkg::TX_STOP;
                            end
                        end
                        uart_pkg::TX_PAR: tx_st_q <= uart_pkg::TX_STOP;
                        uart_pkg::TX_STOP: begin
                            if (stop_q && !tx_stop2_q) tx_stop2_q <= 1'b1;
                            else tx_st_q <= uart_pkg::TX_IDLE;
                        end
                        default: tx_st_q <= uart_pkg::TX_IDLE;
                    endcase
                end
            end
        end
    end

    always_comb begin
        case (tx_st_q)
            uart_pkg::TX_START: tx_bit = 1'b0;
            uart_pkg::TX_DATA: tx_bit = tx_sr_q[0];
            uart_pkg::TX_PAR: tx_bit = tx_par_q;
            default: tx_bit = 1'b1;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_line_q <= 1'b1;
            tx_irq_q <= 1'b0;
        end else if (ce) begin
            if (!module_enable) tx_line_q <= 1'b1;
            else if (send_break) tx_line_q <= 1'b0;
            else tx_line_q <= tx_bit;
            tx_irq_q <= tx_pop && (!tx_irq_select || txf.count == uart_pkg::CNT_ONE);
        end
    end

    assign primary_tx_pin = alt_sel_q ? 1'b1 : tx_line_q;
    assign alt_tx_pin = alt_sel_q ? tx_line_q : 1'b1;
    assign tx_shift_empty = (tx_st_q == uart_pkg::TX_IDLE);
    assign tx_full = (txf.count == uart_pkg::CNT_FULL);
    assign tx_irq_flag = tx_irq_q;

    // ================================
    // receiver
    uart_pkg::rx_state_t rx_st_q;
    logic rx_meta_q;
    logic rx_sync_q;
    logic [3:0] rx_phase_q;
    logic [3:0] rx_bit_q;
    logic [8:0] rx_sr_q;
    logic rx_parbit_q;
    logic rx_framing_err_q;
    logic rx_stop2_q;
    logic ovr_q;
    logic rx_irq_q;
    logic rx_done;
    logic rx_push;
    logic frame_framing_err;
    logic frame_parity_err;
    logic [8:0] frame_data;
    logic [uart_pkg::RX_ENTRY_W-1:0] head_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
        end else if (ce) begin
            rx_meta_q <= alt_sel_q ? alt_rx_pin : primary_rx_pin;
            rx_sync_q <= rx_meta_q;
        end
    end

    assign rx_done = tick && rx_st_q == uart_pkg::RX_STOP
        && rx_phase_q == uart_pkg::PHASE_LAST && (!stop_q || rx_stop2_q);
    assign frame_framing_err = rx_framing_err_q || !rx_sync_q;
    assign frame_data = (nbits == uart_pkg::BITS_9) ? rx_sr_q : {1'b0, rx_sr_q[8:1]};
    assign frame_parity_err = has_par && ((fmt_q == uart_pkg::FMT_8E)
        ? (^frame_data[7:0] ^ rx_parbit_q) : ~(^frame_data[7:0] ^ rx_parbit_q));
    assign rx_push = rx_done && rxf.wr_ready;
    assign rxf.wr_valid = rx_push;
    assign rxf.wr_data = {frame_framing_err, frame_parity_err, frame_data};
    assign rxf.rd_ready = ce && rx_rd_stb && module_enable;
    assign rxf.flush = !module_enable;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rx_st_q <= uart_pkg::RX_IDLE;
            rx_phase_q <= 4'h0;
            rx_bit_q <= 4'h0;
            rx_sr_q <= 9'h000;
            rx_parbit_q <= 1'b0;
            rx_framing_err_q <= 1'b0;
            rx_stop2_q <= 1'b0;
        end else if (ce) begin
            if (!module_enable) begin
                rx_st_q <= uart_pkg::RX_IDLE;
            end else begin
                if (tick) rx_phase_q <= rx_phase_q + 4'h1;
                case (rx_st_q)
                    uart_pkg::RX_IDLE: begin
                        if (!rx_sync_q) begin
                            rx_st_q <= uart_pkg::RX_START;
                            rx_phase_q <= 4'h0;
                        end
                    end
                    uart_pkg::RX_START: begin
                        if (tick && rx_phase_q == uart_pkg::PHASE_MID) begin
                            // realign so later samples land mid-bit
                            rx_phase_q <= 4'h0;
                            rx_bit_q <= 4'h0;
                            rx_st_q <= rx_sync_q ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
                        end
                    end
                    uart_pkg::RX_DATA: begin
                        if (tick && rx_phase_q == uart_pkg::PHASE_LAST) begin
                            rx_sr_q <= {rx_sync_q, rx_sr_q[8:1]};
                            rx_bit_q <= rx_bit_q + 4'h1;
                            rx_framing_err_q <= 1'b0;
                            rx_stop2_q <= 1'b0;
                            if (rx_bit_q == nbits - 4'h1) begin
                                rx_st_q <= has_par ? uart_pkg::RX_PAR : uart_pkg::RX_STOP;
                            end
                        end
                    end
                    uart_pkg::RX_PAR: begin
                        if (tick && rx_phase_q == uart_pkg::PHASE_LAST) begin
                            rx_parbit_q <= rx_sync_q;
                            rx_st_q <= uart_pkg::RX_STOP;
                        end
                    end
                    uart_pkg::RX_STOP: begin
                        if (rx_done) begin
                            if (!rxf.wr_ready) rx_st_q <= uart_pkg::RX_HOLD;
                            else if (frame_framing_err) rx_st_q <= uart_pkg::RX_WAITHI;
                            else rx_st_q <= uart_pkg::RX_IDLE;
                        end else if (tick && rx_phase_q == uart_pkg::PHASE_LAST) begin
                            rx_framing_err_q <= rx_framing_err_q || !rx_sync_q;
                            rx_stop2_q <= 1'b1;
                        end
                    end
                    // shifting stays halted until software clears the overrun
                    uart_pkg::RX_HOLD: if (!ovr_q) rx_st_q <= uart_pkg::RX_WAITHI;
                    uart_pkg::RX_WAITHI: if (rx_sync_q) rx_st_q <= uart_pkg::RX_IDLE;
                    default: rx_st_q <= uart_pkg::RX_IDLE;
                endcase
            end
        end
    end

    // ================================
    // receive status and events
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ovr_q <= 1'b0;
            rx_irq_q <= 1'b0;
            head_q <= '0;
        end else if (ce) begin
            if (!module_enable) ovr_q <= 1'b0;
            else if (rx_done && !rxf.wr_ready) ovr_q <= 1'b1;
            else if (overrun_clr) ovr_q <= 1'b0;
            rx_irq_q <= rx_push && (!rx_irq_select[1]
                || (rx_irq_select == uart_pkg::RX_SEL_THREE && rxf.count == uart_pkg::CNT_TWO)
                || (rx_irq_select == uart_pkg::RX_SEL_FOUR && rxf.count == uart_pkg::CNT_THREE)
            );
            // empty fifo leaves the old slot in view
            head_q <= module_enable ? rxf.rd_data : '0;
        end
    end

    assign rx_rd_data = head_q[8:0];
    assign parity_err = head_q[9];
    assign framing_err = head_q[10];
    assign rx_data_avail = (rxf.count != '0);
    assign overrun_err = ovr_q;
    assign rx_idle = (rx_st_q == uart_pkg::RX_IDLE) || (rx_st_q == uart_pkg::RX_WAITHI)
        || (rx_st_q == uart_pkg::RX_HOLD);
    assign rx_irq_flag = rx_irq_q;

    // ================================
    // checks
    sequence s_brk_push;
        ce && rx_push && frame_framing_err;
    endsequence

    brk_low_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && module_enable && send_break |=> !tx_line_q)
        else $error("break did not force the line low");
    idle_high_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && module_enable && !send_break && tx_st_q == uart_pkg::TX_IDLE |=> tx_line_q)
        else $error("idle transmitter line not high");
    tx_irq_each_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        tx_pop && !tx_irq_select |=> tx_irq_flag)
        else $error("transfer irq missing");
    tx_irq_empty_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        tx_pop && tx_irq_select && txf.count != uart_pkg::CNT_ONE |=> !tx_irq_flag)
        else $error("empty-mode irq fired early");
    tx_full_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && module_enable && txf.count == uart_pkg::CNT_THREE && tx_wr_stb && !tx_pop
        |=> tx_full)
        else $error("tx_full missing at four words");
    rx_avail_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && rx_push && !rxf.rd_ready |=> rx_data_avail)
        else $error("data available not shown");
    overrun_set_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && rx_done && !rxf.wr_ready |=> overrun_err && rx_st_q == uart_pkg::RX_HOLD)
        else $error("overrun not raised");
    rx_busy_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        rx_st_q == uart_pkg::RX_DATA || rx_st_q == uart_pkg::RX_STOP |-> !rx_idle)
        else $error("idle shown during a frame");
    brk_wait_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_brk_push |=> rx_st_q == uart_pkg::RX_WAITHI && rx_idle)
        else $error("break frame did not wait for high line");
    rx_irq_full_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && rx_push && rx_irq_select == 2'h3 && rxf.count == 3'h3 |=> rx_irq_flag)
        else $error("four-word irq missing");
endmodule

// ===== async_serial_transceiver_fifo_tb.sv
// bench: transceiver against a remote station and an integer frame model
`timescale 1ns/10ps
module async_serial_transceiver_fifo_tb;
    logic clk_sys = 1'b0, rstn = 1'b0, ce = 1'b1, module_enable = 1'b1, alt_pin_select = 1'b0;
    logic [1:0] format_select = 2'h0, rx_irq_select = 2'h0;
    logic stop_select = 1'b0, tx_enable = 1'b1, send_break = 1'b0, tx_irq_select = 1'b0;
    logic [15:0] baud_div = 16'h0001;
    logic tx_wr_stb = 1'b0, rx_rd_stb = 1'b0, overrun_clr = 1'b0;
    logic [8:0] tx_wr_data = 9'h000;
    logic [8:0] rx_rd_data;
    logic tx_full, tx_shift_empty, rx_data_avail, overrun_err, framing_err, parity_err, rx_idle;
    logic tx_irq_flag, rx_irq_flag, primary_tx_pin, alt_tx_pin, line_rx;
    wire logic primary_rx_pin = alt_pin_select | line_rx;
    wire logic alt_rx_pin = ~alt_pin_select | line_rx;
    int errors = 0, samples_checked = 0, cycles = 0, n_txi = 0, n_rxi = 0;
    logic [31:0] d, s;
    async_serial_transceiver_fifo dut (.clk_sys, .rstn, .ce, .module_enable, .alt_pin_select,
        .format_select, .stop_select, .tx_enable, .send_break, .tx_irq_select, .rx_irq_select,
        .baud_div, .tx_wr_stb, .tx_wr_data, .rx_rd_stb, .rx_rd_data, .overrun_clr, .tx_full,
        .tx_shift_empty, .rx_data_avail, .overrun_err, .framing_err, .parity_err, .rx_idle,
        .tx_irq_flag, .rx_irq_flag, .primary_rx_pin, .alt_rx_pin, .primary_tx_pin, .alt_tx_pin);
    remote_station p (.clk_sys, .fmt(format_select), .two_stop(stop_select),
        .line_in(alt_pin_select ? alt_tx_pin : primary_tx_pin), .line_out(line_rx));
    initial forever #12.5 clk_sys = ~clk_sys;
    // hang guard and event counters
    always @(posedge clk_sys) begin
        cycles++;
        if (tx_irq_flag === 1'b1) n_txi++;
        if (rx_irq_flag === 1'b1) n_rxi++;
        if (cycles == 60000) begin
            errors++;
            wrap_up();
        end
    end
    // ====
    // model and helpers
    function automatic int frame(int v, logic [1:0] f, logic st);
        int n;
        n = (f == 2'h3) ? 9 : 8;
        v = v & ((1 << n) - 1);
        if (f == 2'h1 || f == 2'h2) begin
            v = v | (int'((^v[7:0]) ^ (f == 2'h2)) << n);
            n++;
        end
        return v | ((st ? 3 : 1) << n);
    endfunction
    task automatic tick(int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic chk(logic [31:0] g, logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(int v);
        tx_wr_data = 9'(v);
        tx_wr_stb = 1'b1;
        tick(1);
        tx_wr_stb = 1'b0;
        tick(1);
    endtask
    task automatic txget(int e);
        for (int k = 0; k < 900 && p.rxq.size() == 0; k++) tick(1);
        chk(p.rxq.size() ? p.rxq.pop_front() : -1, e);
    endtask
    task automatic rxread(int e);
        for (int k = 0; k < 900 && rx_data_avail !== 1'b1; k++) tick(1);
        tick(3);
        chk({framing_err, parity_err, rx_rd_data}, e);
        rx_rd_stb = 1'b1;
        tick(1);
        rx_rd_stb = 1'b0;
        tick(3);
    endtask
    task automatic wrap_up();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ====
    // main sequence
    initial begin
        void'($urandom(17483));
        tick(8);
        rstn = 1'b1;
        tick(1);
        chk({primary_tx_pin, alt_tx_pin, rx_idle, tx_shift_empty, tx_full, rx_data_avail,
            overrun_err, framing_err, parity_err, tx_irq_flag, rx_irq_flag}, 32'h780);
        for (int f = 0; f < 8; f++) begin
            format_select = 2'(f / 2);
            stop_select = 1'(f % 2);
            d = $urandom_range(511, 0);
            tick(2);
            wr(d);
            txget(frame(d, format_select, stop_select));
            s = frame($urandom_range(511, 0), format_select, 1'b0) ^ ((f % 2) << 8);
            p.send(s, 9 + (f > 1));
            rxread((s & (f > 5 ? 511 : 255)) | ((f == 3 || f == 5) << 9) | ((f == 1) << 10));
        end
        chk(n_txi, 8);
        chk(n_rxi, 8);
        format_select = 2'h0;
        stop_select = 1'b0;
        tx_enable = 1'b0;
        tx_irq_select = 1'b1;
        tick(2);
        for (int i = 0; i < 5; i++) wr(i + 16);
        chk(tx_full, 1);
        n_txi = 0;
        tx_enable = 1'b1;
        for (int i = 0; i < 4; i++) txget(frame(i + 16, 2'h0, 1'b0));
        tick(400);
        chk({p.rxq.size(), n_txi[3:0]}, 1);
        rx_irq_select = 2'h3;
        n_rxi = 0;
        for (int i = 0; i < 5; i++) p.send(frame(i + 32, 2'h0, 1'b0), 9);
        tick(40);
        chk({overrun_err, n_rxi[1:0]}, 5);
        for (int i = 0; i < 4; i++) rxread(i + 32);
        d = rx_rd_data;
        rx_rd_stb = 1'b1;
        tick(1);
        rx_rd_stb = 1'b0;
        tick(3);
        chk({rx_data_avail, rx_rd_data}, d);
        overrun_clr = 1'b1;
        tick(1);
        overrun_clr = 1'b0;
        rx_irq_select = 2'h0;
        tick(2);
        chk(overrun_err, 0);
        p.send(0, 14);
        rxread(32'h400);
        p.send(frame(85, 2'h0, 1'b0), 9);
        rxread(85);
        rx_irq_select = 2'h2;
        n_rxi = 0;
        for (int i = 0; i < 3; i++) p.send(frame(i + 48, 2'h0, 1'b0), 9);
        tick(40);
        chk(n_rxi, 1);
        for (int i = 0; i < 3; i++) rxread(i + 48);
        rx_irq_select = 2'h0;
        alt_pin_select = 1'b1;
        tick(2);
        wr(170);
        txget(frame(170, 2'h0, 1'b0));
        chk(primary_tx_pin, 1);
        n_txi = 0;
        send_break = 1'b1;
        tick(3);
        chk({primary_tx_pin, alt_tx_pin}, 2);
        tick(13 * 32);
        send_break = 1'b0;
        tick(64);
        chk(n_txi, 0);
        p.rxq.delete();
        // frozen clock enable keeps the queued word and takes no new one
        tx_enable = 1'b0;
        wr(9);
        ce = 1'b0;
        wr(10);
        tick(20);
        ce = 1'b1;
        tx_enable = 1'b1;
        txget(frame(9, 2'h0, 1'b0));
        tick(400);
        chk(p.rxq.size(), 0);
        p.send(frame(7, 2'h0, 1'b0), 9);
        tick(40);
        chk({rx_data_avail, rx_rd_data}, 32'h207);
        module_enable = 1'b0;
        tick(2);
        chk({rx_data_avail, rx_idle, tx_shift_empty}, 3);
        wrap_up();
    end
endmodule

// ===== fifo_if.sv
// handshake bundle between the transceiver and one of its word fifos
`timescale 1ns/10ps
interface fifo_if #(parameter int W = 9);
    logic wr_valid;
    logic wr_ready;
    logic [W-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [W-1:0] rd_data;
    logic [uart_pkg::CNT_W-1:0] count;
    logic flush;
    modport user (output wr_valid, wr_data, rd_ready, flush,
                  input wr_ready, rd_valid, rd_data, count);
    modport store (input wr_valid, wr_data, rd_ready, flush,
                   output wr_ready, rd_valid, rd_data, count);
endinterface

// ===== remote_station.sv
// far-end serial station model: frame sender and frame decoder
`timescale 1ns/10ps
module remote_station #(parameter int BC = 32) (
    // clock
    input wire logic clk_sys,
    // frame format
    input wire logic [1:0] fmt,
    input wire logic two_stop,
    // serial line
    input wire logic line_in,
    output logic line_out
);
    int rxq[$];
    initial line_out = 1'b1;
    // ====
    // decoder: lsb first, parity and stops kept above the data
    initial begin
        int w;
        forever begin
            @(negedge line_in);
            repeat (BC / 2) @(posedge clk_sys);
            w = 0;
            for (int i = 0; i < 9 + (fmt != 2'h0) + two_stop; i++) begin
                repeat (BC) @(posedge clk_sys);
                w[i] = line_in;
            end
            rxq.push_back(w);
        end
    end
    // ====
    // sender: low start, n bits of w, then back to idle high
    task automatic send(input int w, input int n);
        line_out = 1'b0;
        for (int i = 0; i <= n; i++) begin
            repeat (BC) @(negedge clk_sys);
            line_out = (i < n) ? w[i] : 1'b1;
        end
    endtask
endmodule

// ===== uart_pkg.sv
// constants, formats and state types shared by the serial transceiver
package uart_pkg;
    localparam int DATA_W = 9;
    localparam int RX_ENTRY_W = 11;
    localparam int FIFO_DEPTH = 4;
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] CNT_FULL = 3'h4;
    localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
    localparam logic [CNT_W-1:0] CNT_TWO = 3'h2;
    localparam logic [CNT_W-1:0] CNT_THREE = 3'h3;
    // format select encodings
    localparam logic [1:0] FMT_8N = 2'h0;
    localparam logic [1:0] FMT_8E = 2'h1;
    localparam logic [1:0] FMT_8O = 2'h2;
    localparam logic [1:0] FMT_9N = 2'h3;
    localparam logic [1:0] FORMAT_RESET = FMT_8N;
    localparam logic STOP_RESET = 1'b0;
    localparam logic [1:0] RX_SEL_THREE = 2'h2;
    localparam logic [1:0] RX_SEL_FOUR = 2'h3;
    // oversampling: 16 sub-ticks per bit, sample in the middle
    localparam logic [3:0] PHASE_LAST = 4'hF;
    localparam logic [3:0] PHASE_MID = 4'h7;
    localparam logic [3:0] BITS_8 = 4'h8;
    localparam logic [3:0] BITS_9 = 4'h9;
    localparam logic [15:0] DIV_RESET = 16'h0000;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_HOLD, RX_WAITHI
    } rx_state_t;
endpackage

// ===== word_fifo.sv
// four-word fifo with valid/ready on both sides
`timescale 1ns/10ps
module word_fifo #(parameter int W = 9) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // both sides of the buffer
    fifo_if.store f
);
    logic [W-1:0] mem_q [uart_pkg::FIFO_DEPTH];
    logic [1:0] wr_ptr_q;
    logic [1:0] rd_ptr_q;
    logic [uart_pkg::CNT_W-1:0] count_q;
    logic push;
    logic pop;

    assign f.wr_ready = (count_q != uart_pkg::CNT_FULL);
    assign f.rd_valid = (count_q != '0);
    // empty read shows the old slot: stale data, no pointer move
    assign f.rd_data = mem_q[rd_ptr_q];
    assign f.count = count_q;
    assign push = f.wr_valid && f.wr_ready;
    assign pop = f.rd_ready && f.rd_valid;

    // ================================
    // pointers and fill level
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_q <= 2'h0;
            rd_ptr_q <= 2'h0;
            count_q <= '0;
        end else if (ce) begin
            if (f.flush) begin
                wr_ptr_q <= 2'h0;
                rd_ptr_q <= 2'h0;
                count_q <= '0;
            end else begin
                if (push) wr_ptr_q <= wr_ptr_q + 2'h1;
                if (pop) rd_ptr_q <= rd_ptr_q + 2'h1;
                if (push && !pop) count_q <= count_q + 3'h1;
                else if (pop && !push) count_q <= count_q - 3'h1;
            end
        end
    end

    // ================================
    // storage
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < uart_pkg::FIFO_DEPTH; i++) mem_q[i] <= '0;
        end else if (ce && push && !f.flush) begin
            mem_q[wr_ptr_q] <= f.wr_data;
        end
    end

    fifo_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ce && !f.flush && count_q == uart_pkg::CNT_FULL && f.wr_valid && !f.rd_ready
        |=> count_q == uart_pkg::CNT_FULL && $stable(wr_ptr_q) && $stable(rd_ptr_q))
        else $error("write into a full fifo changed it");
endmodule
